// ===== pkg/dual_timer_pkg.sv
// Purpose: constants and carrier types of the dual timer/counter block
// Assumes: AHB-Lite word access, one register per aligned word
// Notes:   register indices map to byte addresses by a factor of four
package dual_timer_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int         ADDR_W            = 12;
    localparam logic [9:0] IDX_CONTROL_FLAGS = 10'h088;
    localparam logic [9:0] IDX_MODE_CONFIG   = 10'h089;
    localparam logic [9:0] IDX_LOW_A         = 10'h08a;
    localparam logic [9:0] IDX_LOW_B         = 10'h08b;
    localparam logic [9:0] IDX_HIGH_A        = 10'h08c;
    localparam logic [9:0] IDX_HIGH_B        = 10'h08d;
    localparam logic [9:0] IDX_AUX_CONTROL   = 10'h0ce;
    localparam logic [9:0] IDX_IRQ_ENABLE    = 10'h0a8;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         FLAG_LSB      = 5;
    localparam int         RUN_LSB       = 4;
    localparam int         MODE_FIELD_W  = 4;
    localparam int         PRESCALE_LSB  = 2;
    localparam int         TOGGLE_LSB    = 0;
    localparam logic [7:0] BYTE_RESET    = 8'h00;
    localparam logic [7:0] BYTE_ONES     = 8'hff;
    localparam logic [4:0] LOW13_ONES    = 5'h1f;

    // ------------------------------------------------------------
    // modes, divider and bus codes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_13BIT    = 2'h0;
    localparam logic [1:0] MODE_16BIT    = 2'h1;
    localparam logic [1:0] MODE_8RELOAD  = 2'h2;
    localparam int         PRESCALE_DIV  = 12;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic       gate_select;
        logic       count_source;
        logic [1:0] mode_select_field;
    } timer_cfg_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
    } bus_phase_t;

endpackage

// ===== verilog/dual_timer.sv
// Purpose: two 16-bit timer/counters with 13-bit, 16-bit and 8-bit reload modes
// Assumes: single clock hclk, AHB-Lite slave with zero wait states
// Notes:   mode 3 holds the count still; counting pins are sampled on hclk
//
// Design decisions made here: the AHB-Lite register port and the register addresses.

// How it works
// - each timer keeps a 16-bit count as high and low bytes
// - each timer has its own two-bit mode field
// - mode 00 is 13-bit, 01 is 16-bit, 10 is 8-bit reload, all up
// - 13-bit mode counts low bits 4..0 then carries into high byte
// - rollover sets the overflow flag and requests an enabled interrupt
// - flag stays until software clears it; writing one sets it and raises an enabled interrupt
// - count source one counts falling edges on the count pin
// - count source zero counts the internal timer clock
// - counting needs run and either no gate or a high gate pin
// - starting the timer keeps the held count
// - timer clock is the system clock or that clock over twelve
// - prescale zero picks divide by twelve, one undivided; resets zero
// - with toggle enable in timer mode the pin inverts on overflow
// - toggle enable forces the pin to output
// - 16-bit mode counts across all sixteen bits
// - 8-bit reload mode counts low byte, high byte holds reload
// - low byte rollover sets flag and reloads from the high byte
// - overflow reaches the interrupt only with its enable bit
// - all count, mode and control bits reset to zero
module dual_timer
    import dual_timer_pkg::*;
#(
    parameter int DIVIDE = PRESCALE_DIV
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic [31:0]            hrdata,
    output logic                   hresp,
    input  wire logic [1:0]        count_pin_in,
    output logic [1:0]             count_pin_out,
    output logic [1:0]             count_pin_oe,
    input  wire logic [1:0]        external_gate_pin,
    output logic [1:0]             timer_irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    timer_cfg_t  cfg_reg [2];
    logic [7:0]  low_reg [2];
    logic [7:0]  high_reg [2];
    logic [1:0]  run_control_reg;
    logic [1:0]  overflow_flag_reg;
    logic [1:0]  clock_prescale_select_reg;
    logic [1:0]  overflow_toggle_enable_reg;
    logic [1:0]  irq_enable_group_reg;
    logic [1:0]  pin_meta_reg;
    logic [1:0]  pin_sync_reg;
    logic [1:0]  pin_last_reg;
    logic [1:0]  gate_meta_reg;
    logic [1:0]  gate_sync_reg;
    logic [3:0]  pre_cnt_reg;
    bus_phase_t  phase_reg;

    // ------------------------------------------------------------
    // one counting step: returns {overflow, high, low}
    // ------------------------------------------------------------
    function automatic logic [16:0] step(input logic [1:0] mode,
                                         input logic [7:0] hi,
                                         input logic [7:0] lo);
        logic [5:0]  low5;
        logic [16:0] res;
        low5 = 6'({1'b0, lo[4:0]}) + 6'h01;
        res  = {1'b0, hi, lo};
        case (mode)
            MODE_13BIT: begin
                res = {(lo[4:0] == LOW13_ONES) && (hi == BYTE_ONES),
                       8'(hi + {7'h00, low5[5]}), lo[7:5], low5[4:0]};
            end
            MODE_16BIT: begin
                res = 17'({1'b0, hi, lo} + 17'h00001);
            end
            MODE_8RELOAD: begin
                res = (lo == BYTE_ONES) ? {1'b1, hi, hi} : {1'b0, hi, 8'(lo + 8'h01)};
            end
            default: begin
                res = {1'b0, hi, lo};
            end
        endcase
        return res;
    endfunction

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire        take_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
    wire [9:0]  rd_idx     = haddr[ADDR_W-1:2];
    wire [9:0]  wr_idx     = phase_reg.addr[ADDR_W-1:2];
    wire        wr_go      = phase_reg.valid && phase_reg.write;
    wire [7:0]  wbyte      = hwdata[7:0];
    wire        wr_flags   = wr_go && (wr_idx == IDX_CONTROL_FLAGS);
    wire        wr_mode    = wr_go && (wr_idx == IDX_MODE_CONFIG);
    wire        wr_aux     = wr_go && (wr_idx == IDX_AUX_CONTROL);
    wire        wr_irq_en  = wr_go && (wr_idx == IDX_IRQ_ENABLE);
    wire [1:0]  wr_low     = {wr_go && (wr_idx == IDX_LOW_B), wr_go && (wr_idx == IDX_LOW_A)};
    wire [1:0]  wr_high    = {wr_go && (wr_idx == IDX_HIGH_B), wr_go && (wr_idx == IDX_HIGH_A)};
    wire [7:0]  flags_byte = {overflow_flag_reg[1], run_control_reg[1],
                              overflow_flag_reg[0], run_control_reg[0], 4'h0};
    wire [7:0]  mode_byte  = {cfg_reg[1], cfg_reg[0]};
    wire [7:0]  aux_byte   = {4'h0, clock_prescale_select_reg, overflow_toggle_enable_reg};
    logic [7:0] rd_byte;

    always_comb begin
        if (rd_idx == IDX_CONTROL_FLAGS) begin
            rd_byte = flags_byte;
        end else if (rd_idx == IDX_MODE_CONFIG) begin
            rd_byte = mode_byte;
        end else if (rd_idx == IDX_LOW_A) begin
            rd_byte = low_reg[0];
        end else if (rd_idx == IDX_LOW_B) begin
            rd_byte = low_reg[1];
        end else if (rd_idx == IDX_HIGH_A) begin
            rd_byte = high_reg[0];
        end else if (rd_idx == IDX_HIGH_B) begin
            rd_byte = high_reg[1];
        end else if (rd_idx == IDX_AUX_CONTROL) begin
            rd_byte = aux_byte;
        end else if (rd_idx == IDX_IRQ_ENABLE) begin
            rd_byte = {6'h00, irq_enable_group_reg};
        end else begin
            rd_byte = BYTE_RESET;
        end
    end

    // ------------------------------------------------------------
    // count enables and steps
    // ------------------------------------------------------------
    wire        tick12   = (pre_cnt_reg == 4'(DIVIDE - 1));
    wire [1:0]  pin_fall = pin_last_reg & ~pin_sync_reg;
    logic [1:0]  step_en;
    logic [1:0]  ovf;
    logic [16:0] stepped [2];

    for (genvar i = 0; i < 2; i++) begin : g_timer
        wire src_tick = cfg_reg[i].count_source ? pin_fall[i]
                      : (clock_prescale_select_reg[i] || tick12);
        assign step_en[i] = run_control_reg[i] && src_tick
                          && (!cfg_reg[i].gate_select || gate_sync_reg[i]);
        assign stepped[i] = step(cfg_reg[i].mode_select_field, high_reg[i], low_reg[i]);
        assign ovf[i]     = step_en[i] && stepped[i][16];
    end

    // ------------------------------------------------------------
    // synchronisers and prescaler
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta_reg  <= 2'h3;
            pin_sync_reg  <= 2'h3;
            pin_last_reg  <= 2'h3;
            gate_meta_reg <= 2'h0;
            gate_sync_reg <= 2'h0;
            pre_cnt_reg   <= 4'h0;
        end else begin
            pin_meta_reg  <= count_pin_in;
            pin_sync_reg  <= pin_meta_reg;
            pin_last_reg  <= pin_sync_reg;
            gate_meta_reg <= external_gate_pin;
            gate_sync_reg <= gate_meta_reg;
            pre_cnt_reg   <= tick12 ? 4'h0 : 4'(pre_cnt_reg + 4'h1);
        end
    end

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_reg <= '0;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            phase_reg <= '{valid: take_phase, write: hwrite, addr: haddr};
            hrdata    <= (take_phase && !hwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // timer registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 2; i++) begin
                cfg_reg[i]  <= '0;
                low_reg[i]  <= BYTE_RESET;
                high_reg[i] <= BYTE_RESET;
            end
            run_control_reg            <= 2'h0;
            overflow_flag_reg          <= 2'h0;
            clock_prescale_select_reg  <= 2'h0;
            overflow_toggle_enable_reg <= 2'h0;
            irq_enable_group_reg       <= 2'h0;
            count_pin_out              <= 2'h0;
            count_pin_oe               <= 2'h0;
            timer_irq                  <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_mode) begin
                    cfg_reg[i] <= timer_cfg_t'(wbyte[MODE_FIELD_W*i +: MODE_FIELD_W]);
                end
                if (wr_flags) begin
                    run_control_reg[i] <= wbyte[RUN_LSB + 2*i];
                end
                // set by overflow wins over a clearing write
                if (ovf[i]) begin
                    overflow_flag_reg[i] <= 1'b1;
                end else if (wr_flags) begin
                    overflow_flag_reg[i] <= wbyte[FLAG_LSB + 2*i];
                end
                // a write to one byte wins over the step for that byte
                if (wr_low[i]) begin
                    low_reg[i] <= wbyte;
                end else if (step_en[i]) begin
                    low_reg[i] <= stepped[i][7:0];
                end
                if (wr_high[i]) begin
                    high_reg[i] <= wbyte;
                end else if (step_en[i]) begin
                    high_reg[i] <= stepped[i][15:8];
                end
                if (ovf[i] && overflow_toggle_enable_reg[i] && !cfg_reg[i].count_source) begin
                    count_pin_out[i] <= !count_pin_out[i];
                end
            end
            if (wr_aux) begin
                clock_prescale_select_reg  <= wbyte[PRESCALE_LSB +: 2];
                overflow_toggle_enable_reg <= wbyte[TOGGLE_LSB +: 2];
            end
            if (wr_irq_en) begin
                irq_enable_group_reg <= wbyte[1:0];
            end
            count_pin_oe <= overflow_toggle_enable_reg;
            timer_irq    <= overflow_flag_reg & irq_enable_group_reg;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_ovf_sets_flag: assert property (ovf[0] |=> overflow_flag_reg[0])
        else $error("overflow did not set flag");
    a_flag_sticky: assert property ($fell(overflow_flag_reg[0]) |-> $past(wr_flags))
        else $error("flag cleared without a write");
    a_irq_gating: assert property (overflow_flag_reg[0] && irq_enable_group_reg[0]
        |=> timer_irq[0]) else $error("enabled flag gave no interrupt");
    a_irq_masked: assert property (!irq_enable_group_reg[0] |=> !timer_irq[0])
        else $error("masked interrupt raised");
    a_reload_copy: assert property (ovf[0] && !wr_low[0] && !wr_high[0]
        && cfg_reg[0].mode_select_field == MODE_8RELOAD
        |=> low_reg[0] == $past(high_reg[0]) && $stable(high_reg[0]))
        else $error("reload did not copy high byte");
    a_stopped_holds: assert property (!run_control_reg[0] && !wr_low[0] && !wr_high[0]
        |=> $stable(low_reg[0]) && $stable(high_reg[0])) else $error("stopped timer moved");
    a_upper_bits_held: assert property (cfg_reg[0].mode_select_field == MODE_13BIT
        && !wr_low[0] |=> low_reg[0][7:5] == $past(low_reg[0][7:5]))
        else $error("13-bit mode changed low bits 7..5");
    a_pin_toggles: assert property (ovf[0] && overflow_toggle_enable_reg[0]
        && !cfg_reg[0].count_source |=> count_pin_out[0] != $past(count_pin_out[0]))
        else $error("pin did not toggle on overflow");
    a_pin_direction: assert property (overflow_toggle_enable_reg[0] |=> count_pin_oe[0])
        else $error("toggle pin not driven");
    a_divide_period: assert property (tick12 |=> !tick12 [*8])
        else $error("divider ticks too often");
    a_gate_blocks: assert property (cfg_reg[0].gate_select && !gate_sync_reg[0]
        |-> !step_en[0]) else $error("gated timer counted");
    a_edge_steps: assert property (run_control_reg[0] && cfg_reg[0].count_source
        && !cfg_reg[0].gate_select && pin_fall[0] |-> step_en[0])
        else $error("falling edge not counted");
    a_flag_b_set: assert property (ovf[1] |=> overflow_flag_reg[1])
        else $error("overflow did not set flag of timer b");

    c_overflow_16: cover property (ovf[0] && cfg_reg[0].mode_select_field == MODE_16BIT);
    c_overflow_reload: cover property (ovf[1] && cfg_reg[1].mode_select_field == MODE_8RELOAD);
    c_edge_count: cover property (step_en[0] && cfg_reg[0].count_source);
    c_gated_hold: cover property (run_control_reg[0] && cfg_reg[0].gate_select && !gate_sync_reg[0]);
    c_overflow_13: cover property (ovf[0] && cfg_reg[0].mode_select_field == MODE_13BIT);

endmodule

// ===== testbench/pin_model.sv
// Purpose: far-side model of the count and gate pins of both timers
// Assumes: count pins carry a pull-up and idle high
// Notes:   a pulse request gives one low pulse of four clocks
module pin_model (
    input  wire logic       clk,
    input  wire logic [1:0] pulse,
    input  wire logic [1:0] gate_lvl,
    output logic [1:0]      count_drv,
    output logic [1:0]      gate_drv
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] low_cnt [2];
    initial begin
        low_cnt[0] = 3'h0;
        low_cnt[1] = 3'h0;
    end
    // one falling edge per request, long enough to pass two sync stages
    always @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (pulse[i]) low_cnt[i] <= 3'h4;
            else if (low_cnt[i] != 3'h0) low_cnt[i] <= low_cnt[i] - 3'h1;
        end
    end
    assign count_drv[0] = (low_cnt[0] == 3'h0);
    assign count_drv[1] = (low_cnt[1] == 3'h0);
    assign gate_drv     = gate_lvl;
endmodule

// ===== testbench/testbench.sv
// Purpose: self-checking bench of the dual timer over AHB-Lite
// Assumes: zero wait-state slave, pins modelled by pin_model
// Notes:   counts are checked in windows where bus latency blurs them
module testbench import dual_timer_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] CTL = {IDX_CONTROL_FLAGS, 2'b00};
    localparam logic [11:0] MOD = {IDX_MODE_CONFIG, 2'b00};
    localparam logic [11:0] LA  = {IDX_LOW_A, 2'b00};
    localparam logic [11:0] LB  = {IDX_LOW_B, 2'b00};
    localparam logic [11:0] HA  = {IDX_HIGH_A, 2'b00};
    localparam logic [11:0] HB  = {IDX_HIGH_B, 2'b00};
    localparam logic [11:0] AUX = {IDX_AUX_CONTROL, 2'b00};
    localparam logic [11:0] IRQ = {IDX_IRQ_ENABLE, 2'b00};
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0]  htrans, pin_out, pin_oe, cnt_drv, gate_drv, pulse, gate_lvl, irq;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rv;
    logic [1:0]  count_pin;
    logic [7:0]  v;
    logic        o;
    int bad_count, samples_checked;
    assign count_pin = (pin_oe & pin_out) | (~pin_oe & cnt_drv);
    dual_timer #(.DIVIDE(PRESCALE_DIV)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .count_pin_in(count_pin), .count_pin_out(pin_out), .count_pin_oe(pin_oe),
        .external_gate_pin(gate_drv), .timer_irq(irq));
    pin_model partner (.clk(hclk), .pulse(pulse), .gate_lvl(gate_lvl),
        .count_drv(cnt_drv), .gate_drv(gate_drv));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic conclude();
        if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic compare(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rd(input logic [11:0] a);
        bus(a, 1'b0, 8'h00);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [11:0] al [9];
        al = '{CTL, MOD, LA, LB, HA, HB, AUX, IRQ, 12'h004};
        foreach (al[i]) begin rd(al[i]); compare(rv[7:0], 8'h00); end
        compare(rv[31:24], 8'h00);
        compare({7'h00, hresp}, 8'h00);
        compare({4'h0, pin_oe, irq}, 8'h00);
    endtask
    task automatic t_over16();
        wr(LA, 8'hfe);
        wr(HA, 8'hff);
        wr(MOD, 8'h01);
        wr(AUX, 8'h05);
        repeat (2) @(posedge hclk);
        compare(8'(pin_oe[0]), 8'h01);
        o = pin_out[0];
        wr(IRQ, 8'h01);
        wr(CTL, 8'h10);
        repeat (4) @(posedge hclk);
        wr(CTL, 8'h20);
        rd(CTL); compare(8'(rv[5]), 8'h01);
        compare(8'(irq[0]), 8'h01);
        rd(HA); compare(rv[7:0], 8'h00);
        compare(8'(pin_out[0]), {7'h00, ~o});
        wr(CTL, 8'h00);
        wr(AUX, 8'h00);
        compare(8'(irq[0]), 8'h00);
    endtask
    task automatic t_reload();
        wr(HB, 8'hf0);
        wr(LB, 8'hfe);
        wr(MOD, 8'h20);
        wr(AUX, 8'h08);
        wr(IRQ, 8'h00);
        wr(CTL, 8'h40);
        repeat (4) @(posedge hclk);
        wr(CTL, 8'h80);
        rd(CTL); compare(8'(rv[7]), 8'h01);
        compare(8'(irq[1]), 8'h00);
        rd(HB); compare(rv[7:0], 8'hf0);
        rd(LB); compare(8'(rv[7:4]), 8'h0f);
        wr(CTL, 8'h00);
    endtask
    task automatic t_mode13();
        wr(LA, 8'h1f);
        wr(HA, 8'hff);
        wr(MOD, 8'h00);
        wr(AUX, 8'h04);
        wr(CTL, 8'h10);
        repeat (4) @(posedge hclk);
        wr(CTL, 8'h20);
        rd(CTL); compare(8'(rv[5]), 8'h01);
        rd(HA); compare(rv[7:0], 8'h00);
        rd(LA); compare(8'(rv[4:0] < 5'h10), 8'h01);
        wr(CTL, 8'h00);
    endtask
    task automatic t_prescale();
        wr(LA, 8'h00);
        wr(HA, 8'h00);
        wr(MOD, 8'h01);
        wr(AUX, 8'h00);
        wr(CTL, 8'h10);
        repeat (60) @(posedge hclk);
        wr(CTL, 8'h00);
        rd(LA); compare(8'(rv[7:0] >= 8'h4 && rv[7:0] <= 8'h6), 8'h01);
    endtask
    task automatic t_gate();
        wr(LA, 8'h00);
        wr(MOD, 8'h09);
        wr(AUX, 8'h04);
        wr(CTL, 8'h10);
        repeat (20) @(posedge hclk);
        rd(LA); compare(rv[7:0], 8'h00);
        gate_lvl <= 2'b01;
        repeat (20) @(posedge hclk);
        gate_lvl <= 2'b00;
        repeat (4) @(posedge hclk);
        wr(CTL, 8'h00);
        rd(LA); v = rv[7:0];
        compare(8'(v >= 8'd16 && v <= 8'd24), 8'h01);
        wr(MOD, 8'h01);
        wr(CTL, 8'h10);
        wr(CTL, 8'h00);
        rd(LA); compare(8'(rv[7:0] > v && rv[7:0] <= v + 8'd4), 8'h01);
    endtask
    task automatic t_counter();
        wr(LB, 8'h00);
        wr(HB, 8'h00);
        wr(MOD, 8'h50);
        wr(CTL, 8'h40);
        repeat (3) begin
            pulse <= 2'b10;
            @(posedge hclk);
            pulse <= 2'b00;
            repeat (10) @(posedge hclk);
        end
        wr(CTL, 8'h00);
        rd(LB); compare(rv[7:0], 8'h03);
    endtask
    task automatic t_soft_flag();
        wr(IRQ, 8'h02);
        wr(CTL, 8'ha0);
        repeat (3) @(posedge hclk);
        compare({6'h0, irq}, 8'h02);
        wr(CTL, 8'h00);
        repeat (3) @(posedge hclk);
        compare({6'h0, irq}, 8'h00);
        // mode 11 is not a counting mode: the count must hold
        wr(LA, 8'h33);
        wr(MOD, 8'h03);
        wr(AUX, 8'h04);
        wr(CTL, 8'h10);
        repeat (4) @(posedge hclk);
        wr(CTL, 8'h00);
        rd(LA); compare(rv[7:0], 8'h33);
    endtask
    // ------------------------------------------------------------
    // clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    initial begin
        #200000;
        bad_count++;
        conclude();
    end
    initial begin
        {hresetn, hsel, hwrite, haddr, htrans, hwdata, pulse, gate_lvl} = '0;
        hsize = 3'h2;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_over16();
        t_reload();
        t_mode13();
        t_prescale();
        t_gate();
        t_counter();
        t_soft_flag();
        conclude();
    end
endmodule
